// File: slrx_map.vh
// slrx_map.vh: constants of the serial link frame receiver
`ifndef SLRX_MAP_VH
`define SLRX_MAP_VH
// ****************************************
// primitive codes on the phy side
// ****************************************
`define SLRX_P_NONE 4'h0
`define SLRX_P_X_RDY 4'h1
`define SLRX_P_SOF 4'h2
`define SLRX_P_EOF 4'h3
`define SLRX_P_HOLD 4'h4
`define SLRX_P_HOLDA 4'h5
`define SLRX_P_SYNC 4'h6
`define SLRX_P_WTRM 4'h7
`define SLRX_P_R_RDY 4'h8
`define SLRX_P_R_IP 4'h9
`define SLRX_P_R_OK 4'ha
`define SLRX_P_R_ERR 4'hb
`define SLRX_P_DMAT 4'hc
// ****************************************
// frame crc
// ****************************************
`define SLRX_CRC_POLY 32'h04c11db7
`define SLRX_CRC_INIT 32'h52325032
// ****************************************
// buffer sizing
// ****************************************
`define SLRX_FIFO_DEPTH 8
`define SLRX_FIFO_AW 3
`define SLRX_DATA_W 32
`define SLRX_HEADROOM 4
`endif

// File: slrx_fifo.v
// slrx_fifo.v: receive data fifo with registered output stage
`default_nettype none
module slrx_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg [WIDTH-1:0] o_out_data,
  output wire [AW:0] o_level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0] wr_ptr; // write index
  reg [AW-1:0] rd_ptr; // read index
  reg [AW:0] count; // words in storage
  wire wr_en; // accepted write
  wire rd_en; // move into output stage
  assign o_in_ready = (count < DEPTH[AW:0]);
  assign o_level = count;
  assign wr_en = i_in_valid & o_in_ready;
  assign rd_en = (count != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);
  // ****************************************
  // storage and pointers
  // ****************************************
  always @(posedge i_clk) begin
    if (i_ce && wr_en) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
  // pointer and count update
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      if (wr_en) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (rd_en) begin
        rd_ptr <= rd_ptr + 1'b1;
        o_out_data <= mem[rd_ptr];
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0; // output stage drained
      end
      if (wr_en && !rd_en) begin
        count <= count + 1'b1;
      end else if (rd_en && !wr_en) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: slrx_crc.v
// slrx_crc.v: running frame crc over received dwords
`default_nettype none
`include "slrx_map.vh"
module slrx_crc (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_init,
  input wire i_feed,
  input wire [31:0] i_data,
  output reg [31:0] o_crc
);
  // one dword step, msb first
  function [31:0] slrx_crc_step;
    input [31:0] crc;
    input [31:0] data;
    integer k;
    reg [31:0] c;
    begin
      c = crc;
      for (k = 31; k >= 0; k = k - 1) begin
        if (c[31] ^ data[k]) begin
          c = {c[30:0], 1'b0} ^ `SLRX_CRC_POLY;
        end else begin
          c = {c[30:0], 1'b0};
        end
      end
      slrx_crc_step = c;
    end
  endfunction
  // ****************************************
  // accumulator
  // ****************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_crc <= `SLRX_CRC_INIT;
    end else if (i_ce) begin
      if (i_init) begin
        o_crc <= `SLRX_CRC_INIT;
      end else if (i_feed) begin
        o_crc <= slrx_crc_step(o_crc, i_data);
      end
    end
  end
endmodule
`default_nettype wire

// File: slrx_link.v
// slrx_link.v: receive-side link state machine of the serial link
// Notes on behaviour
// - phy not ready: notify, fail, enter no-comm
// - check-ready sends R_RDY awaiting SOF
// - repeated X_RDY keeps check-ready
// - SOF in check-ready enters data
// - other dword in check-ready: notify, idle
// - X_RDY without buffer: wait state, send SYNC
// - waiting: X_RDY with buffer goes check-ready
// - waiting: non X_RDY notifies, goes idle
// - data dwords forwarded and fed to crc
// - data state sends R_IP, DMAT optional
// - data state stays on data/HOLDA/others
// - low buffer space enters hold
// - HOLD in data enters hold-acknowledge
// - EOF to crc check, WTRM to bad end
// - SYNC in data reports abort, idle
// - host pending control frame drops to idle
// - hold sends HOLD, still accepts data
// - hold exits on space with HOLD/other
// - EOF in hold closes frame via headroom
// - SYNC in hold reports illegal, idle
// - hold-acknowledge sends HOLDA, DMAT optional
// - hold-acknowledge reacts to HOLD/EOF/SYNC/other
// - crc check sends R_IP, reports result
// - bad end sends R_ERR until SYNC
`default_nettype none
`include "slrx_map.vh"
module slrx_link #(
  parameter DATA_W = `SLRX_DATA_W,
  parameter DEPTH = `SLRX_FIFO_DEPTH,
  parameter AW = `SLRX_FIFO_AW,
  parameter HEADROOM = `SLRX_HEADROOM
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_phy_ready_flag,
  input wire i_rx_valid,
  input wire i_rx_is_prim,
  input wire [3:0] i_rx_prim,
  input wire [DATA_W-1:0] i_rx_data,
  input wire i_buf_ready,
  input wire i_space_ok,
  input wire i_host_role,
  input wire i_ctrl_frame_pending,
  input wire i_dmat_enable,
  input wire i_dmat_request,
  input wire i_tl_status_valid,
  input wire i_tl_status_good,
  input wire i_rd_ready,
  output wire o_rd_valid,
  output wire [DATA_W-1:0] o_rd_data,
  output reg [3:0] o_tx_prim,
  output reg [3:0] o_state,
  output reg o_nocomm_evt,
  output reg o_proto_evt,
  output reg o_abort_evt,
  output reg o_illegal_evt,
  output reg o_crc_ok_evt,
  output reg o_crc_err_evt
);
  // ****************************************
  // state codes
  // ****************************************
  localparam IDLE_STATE = 4'h0;
  localparam RX_CHECK_READY_STATE = 4'h1;
  localparam RX_WAIT_BUFFER_STATE = 4'h2;
  localparam RX_DATA_STATE = 4'h3;
  localparam RX_HOLD_STATE = 4'h4;
  localparam RX_SEND_HOLD_ACK_STATE = 4'h5;
  localparam RX_FRAME_END_CHECK_STATE = 4'h6;
  localparam RX_GOOD_CRC_STATE = 4'h7;
  localparam RX_GOOD_END_STATE = 4'h8;
  localparam RX_BAD_END_STATE = 4'h9;
  localparam NO_COMM_ERROR_STATE = 4'ha;
  // ****************************************
  // decode helpers
  // ****************************************
  // true when a valid primitive of the given code arrives
  function prim_is;
    input valid;
    input is_prim;
    input [3:0] prim;
    input [3:0] code;
    begin
      prim_is = valid & is_prim & (prim == code);
    end
  endfunction
  // primitive to transmit in a given state
  function [3:0] tx_for;
    input [3:0] st;
    input dmat;
    begin
      case (st)
        RX_CHECK_READY_STATE: tx_for = `SLRX_P_R_RDY;
        RX_WAIT_BUFFER_STATE: tx_for = `SLRX_P_SYNC;
        RX_DATA_STATE: tx_for = dmat ? `SLRX_P_DMAT : `SLRX_P_R_IP;
        RX_HOLD_STATE: tx_for = `SLRX_P_HOLD;
        RX_SEND_HOLD_ACK_STATE: tx_for = dmat ? `SLRX_P_DMAT : `SLRX_P_HOLDA;
        RX_FRAME_END_CHECK_STATE: tx_for = `SLRX_P_R_IP;
        RX_GOOD_CRC_STATE: tx_for = `SLRX_P_R_IP;
        RX_GOOD_END_STATE: tx_for = `SLRX_P_R_OK;
        RX_BAD_END_STATE: tx_for = `SLRX_P_R_ERR;
        default: tx_for = `SLRX_P_SYNC; // idle and no-comm send SYNC
      endcase
    end
  endfunction
  // ****************************************
  // received dword classes
  // ****************************************
  wire rx_xrdy; // X_RDY seen
  wire rx_sof; // SOF seen
  wire rx_eof; // EOF seen
  wire rx_hold; // HOLD seen
  wire rx_sync; // SYNC seen
  wire rx_wtrm; // WTRM seen
  wire rx_dword; // data dword seen
  assign rx_xrdy = prim_is(i_rx_valid, i_rx_is_prim, i_rx_prim, `SLRX_P_X_RDY);
  assign rx_sof = prim_is(i_rx_valid, i_rx_is_prim, i_rx_prim, `SLRX_P_SOF);
  assign rx_eof = prim_is(i_rx_valid, i_rx_is_prim, i_rx_prim, `SLRX_P_EOF);
  assign rx_hold = prim_is(i_rx_valid, i_rx_is_prim, i_rx_prim, `SLRX_P_HOLD);
  assign rx_sync = prim_is(i_rx_valid, i_rx_is_prim, i_rx_prim, `SLRX_P_SYNC);
  assign rx_wtrm = prim_is(i_rx_valid, i_rx_is_prim, i_rx_prim, `SLRX_P_WTRM);
  assign rx_dword = i_rx_valid & ~i_rx_is_prim;
  // ****************************************
  // internal state
  // ****************************************
  reg [3:0] state; // current state
  reg [3:0] next_state; // state for next cycle
  reg pend_valid; // a dword is held back
  reg [DATA_W-1:0] pend_data; // last dword, may be the crc
  reg overrun; // a dword was lost this frame
  reg next_nocomm; // event strobes for next cycle
  reg next_proto;
  reg next_abort;
  reg next_illegal;
  reg next_crc_ok;
  reg next_crc_err;
  wire [AW:0] fifo_level; // words in buffer
  wire fifo_in_ready; // buffer can take a word
  wire [31:0] crc_value; // running crc
  wire space; // room beyond the headroom
  wire in_frame; // states that take data dwords
  wire accept; // a data dword is taken
  wire push; // held dword goes to buffer
  wire crc_match; // frame crc agrees
  wire dmat_now; // termination request in force
  wire abort_host; // host drops the frame
  assign space = i_space_ok & (fifo_level <= DEPTH[AW:0] - HEADROOM[AW:0]);
  assign in_frame = (state == RX_DATA_STATE) | (state == RX_HOLD_STATE) |
    (state == RX_SEND_HOLD_ACK_STATE);
  assign accept = in_frame & rx_dword & i_phy_ready_flag;
  assign push = accept & pend_valid;
  assign crc_match = pend_valid & ~overrun & (crc_value == pend_data[31:0]);
  assign dmat_now = i_dmat_enable & i_dmat_request;
  assign abort_host = i_host_role & i_ctrl_frame_pending;
  // ****************************************
  // next state and events
  // ****************************************
  always @* begin
    next_state = state;
    next_nocomm = 1'b0;
    next_proto = 1'b0;
    next_abort = 1'b0;
    next_illegal = 1'b0;
    next_crc_ok = 1'b0;
    next_crc_err = 1'b0;
    if (!i_phy_ready_flag) begin
      // link lost from any receive state
      if (state != NO_COMM_ERROR_STATE) begin
        next_nocomm = 1'b1;
      end
      next_state = NO_COMM_ERROR_STATE;
    end else begin
      case (state)
        IDLE_STATE: begin
          // transmitter announces a frame
          if (rx_xrdy) begin
            next_state = i_buf_ready ? RX_CHECK_READY_STATE : RX_WAIT_BUFFER_STATE;
          end
        end
        RX_CHECK_READY_STATE: begin
          if (rx_sof) begin
            next_state = RX_DATA_STATE;
          end else if (rx_xrdy) begin
            next_state = RX_CHECK_READY_STATE;
          end else if (i_rx_valid) begin
            next_proto = 1'b1;
            next_state = IDLE_STATE;
          end
        end
        RX_WAIT_BUFFER_STATE: begin
          if (rx_xrdy) begin
            next_state = i_buf_ready ? RX_CHECK_READY_STATE : RX_WAIT_BUFFER_STATE;
          end else if (i_rx_valid) begin
            next_proto = 1'b1;
            next_state = IDLE_STATE;
          end
        end
        RX_DATA_STATE: begin
          if (abort_host) begin
            next_state = IDLE_STATE;
          end else if (rx_sync) begin
            next_abort = 1'b1;
            next_state = IDLE_STATE;
          end else if (rx_eof) begin
            next_state = RX_FRAME_END_CHECK_STATE;
          end else if (rx_wtrm) begin
            next_state = RX_BAD_END_STATE;
          end else if (rx_hold) begin
            next_state = RX_SEND_HOLD_ACK_STATE;
          end else if (!space) begin
            next_state = RX_HOLD_STATE;
          end else begin
            next_state = RX_DATA_STATE;
          end
        end
        RX_HOLD_STATE: begin
          if (abort_host) begin
            next_state = IDLE_STATE;
          end else if (rx_sync) begin
            next_illegal = 1'b1;
            next_state = IDLE_STATE;
          end else if (rx_eof) begin
            next_state = RX_FRAME_END_CHECK_STATE;
          end else if (space && rx_hold) begin
            next_state = RX_SEND_HOLD_ACK_STATE;
          end else if (space && i_rx_valid) begin
            next_state = RX_DATA_STATE;
          end
        end
        RX_SEND_HOLD_ACK_STATE: begin
          if (rx_sync) begin
            next_illegal = 1'b1;
            next_state = IDLE_STATE;
          end else if (rx_eof) begin
            next_state = RX_FRAME_END_CHECK_STATE;
          end else if (rx_hold) begin
            next_state = RX_SEND_HOLD_ACK_STATE;
          end else if (i_rx_valid) begin
            next_state = RX_DATA_STATE;
          end
        end
        RX_FRAME_END_CHECK_STATE: begin
          // crc is settled one cycle after EOF
          if (crc_match) begin
            next_crc_ok = 1'b1;
            next_state = RX_GOOD_CRC_STATE;
          end else begin
            next_crc_err = 1'b1;
            next_state = RX_BAD_END_STATE;
          end
        end
        RX_GOOD_CRC_STATE: begin
          // wait for the transport verdict
          if (rx_sync) begin
            next_illegal = 1'b1;
            next_state = IDLE_STATE;
          end else if (i_tl_status_valid) begin
            next_state = i_tl_status_good ? RX_GOOD_END_STATE : RX_BAD_END_STATE;
          end
        end
        RX_GOOD_END_STATE: begin
          if (rx_sync) begin
            next_state = IDLE_STATE;
          end
        end
        RX_BAD_END_STATE: begin
          if (rx_sync) begin
            next_state = IDLE_STATE;
          end
        end
        NO_COMM_ERROR_STATE: begin
          // phy is back, start over
          next_state = IDLE_STATE;
        end
        default: begin
          next_state = IDLE_STATE;
        end
      endcase
    end
  end
  // ****************************************
  // state, transmit and event registers
  // ****************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= IDLE_STATE;
      o_state <= IDLE_STATE;
      o_tx_prim <= `SLRX_P_SYNC;
      o_nocomm_evt <= 1'b0;
      o_proto_evt <= 1'b0;
      o_abort_evt <= 1'b0;
      o_illegal_evt <= 1'b0;
      o_crc_ok_evt <= 1'b0;
      o_crc_err_evt <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      o_state <= next_state;
      o_tx_prim <= tx_for(next_state, dmat_now);
      o_nocomm_evt <= next_nocomm;
      o_proto_evt <= next_proto;
      o_abort_evt <= next_abort;
      o_illegal_evt <= next_illegal;
      o_crc_ok_evt <= next_crc_ok;
      o_crc_err_evt <= next_crc_err;
    end
  end
  // ****************************************
  // held-back dword and overrun tracking
  // ****************************************
  // the last dword before EOF is the crc and is not forwarded
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_valid <= 1'b0;
      pend_data <= {DATA_W{1'b0}};
      overrun <= 1'b0;
    end else if (i_ce) begin
      if (state == RX_CHECK_READY_STATE) begin
        pend_valid <= 1'b0; // new frame starts clean
        overrun <= 1'b0;
      end else if (accept) begin
        pend_valid <= 1'b1;
        pend_data <= i_rx_data;
        if (push && !fifo_in_ready) begin
          overrun <= 1'b1; // lost word spoils the frame
        end
      end
    end
  end
  // ****************************************
  // receive buffer toward the transport
  // ****************************************
  slrx_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_in_valid(push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(pend_data),
    .o_out_valid(o_rd_valid),
    .i_out_ready(i_rd_ready),
    .o_out_data(o_rd_data),
    .o_level(fifo_level)
  );
  // ****************************************
  // frame crc
  // ****************************************
  slrx_crc u_crc (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_init(state == RX_CHECK_READY_STATE),
    .i_feed(push),
    .i_data(pend_data[31:0]),
    .o_crc(crc_value)
  );
endmodule
`default_nettype wire

// File: slrx_link_chk.sv
// slrx_link_chk.sv: port-level assertions for the link receive state machine
`default_nettype none
`include "slrx_map.vh"
module slrx_link_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_phy_ready_flag,
  input wire logic i_rx_valid,
  input wire logic i_rx_is_prim,
  input wire logic [3:0] i_rx_prim,
  input wire logic i_buf_ready,
  input wire logic i_space_ok,
  input wire logic i_host_role,
  input wire logic i_ctrl_frame_pending,
  input wire logic i_dmat_enable,
  input wire logic [3:0] o_tx_prim,
  input wire logic [3:0] o_state,
  input wire logic o_nocomm_evt,
  input wire logic o_proto_evt,
  input wire logic o_abort_evt,
  input wire logic o_illegal_evt
);
  // ****************************************
  // common qualifiers
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // link live and no host abort pending
  wire logic ok = i_ce && i_phy_ready_flag && !(i_host_role && i_ctrl_frame_pending);
  // primitive taken this cycle
  wire logic tk = ok && i_rx_valid && i_rx_is_prim;
  // ****************************************
  // assertions
  // ****************************************
  a_phy_down_nocomm: assert property (i_ce && !i_phy_ready_flag && o_state != 4'ha
    |=> o_state == 4'ha && o_nocomm_evt) else $error("no-comm not entered");
  a_chk_sends_rrdy: assert property (o_state == 4'h1 |-> o_tx_prim == `SLRX_P_R_RDY)
    else $error("check-ready not sending ready");
  a_chk_xrdy_stays: assert property (o_state == 4'h1 && tk
    && i_rx_prim == `SLRX_P_X_RDY |=> o_state == 4'h1)
    else $error("repeat ready left check-ready");
  a_chk_sof_data: assert property (o_state == 4'h1 && tk && i_rx_prim == `SLRX_P_SOF
    |=> o_state == 4'h3) else $error("start of frame not taken");
  a_chk_other_idle: assert property (o_state == 4'h1 && ok && i_rx_valid
    && !(i_rx_is_prim && i_rx_prim inside {`SLRX_P_X_RDY, `SLRX_P_SOF})
    |=> o_state == 4'h0 && o_proto_evt) else $error("stray dword in check-ready");
  a_wait_sends_sync: assert property (o_state == 4'h2 |-> o_tx_prim == `SLRX_P_SYNC)
    else $error("wait state not sending sync");
  a_wait_xrdy_move: assert property (o_state == 4'h2 && tk
    && i_rx_prim == `SLRX_P_X_RDY |=> o_state == ($past(i_buf_ready) ? 4'h1 : 4'h2))
    else $error("wait state move wrong");
  a_data_sends_rip: assert property (o_state == 4'h3
    && !$past(i_dmat_enable) |-> o_tx_prim == `SLRX_P_R_IP)
    else $error("data state not sending r_ip");
  a_data_sync_abort: assert property (o_state == 4'h3 && i_space_ok && tk
    && i_rx_prim == `SLRX_P_SYNC |=> o_state == 4'h0 && o_abort_evt)
    else $error("sync in data not aborted");
  a_host_abort_idle: assert property (o_state inside {4'h3, 4'h4} && i_ce
    && i_phy_ready_flag && i_host_role && i_ctrl_frame_pending
    |=> o_state == 4'h0 ##0 o_tx_prim == `SLRX_P_SYNC)
    else $error("host abort not honoured");
  a_hold_sends_hold: assert property (o_state == 4'h4 |-> o_tx_prim == `SLRX_P_HOLD)
    else $error("hold state not sending hold");
  a_hold_sync_illegal: assert property (o_state == 4'h4 && tk
    && i_rx_prim == `SLRX_P_SYNC |=> o_state == 4'h0 && o_illegal_evt)
    else $error("sync in hold not reported");
  a_ack_sends_holda: assert property (o_state == 4'h5
    && !$past(i_dmat_enable) |-> o_tx_prim == `SLRX_P_HOLDA)
    else $error("hold-ack not sending holda");
  a_eof_check_once: assert property (o_state == 4'h6 && ok
    |=> o_state inside {4'h7, 4'h9}) else $error("crc check overstayed");
  a_bad_end_rerr: assert property (o_state == 4'h9 |-> o_tx_prim == `SLRX_P_R_ERR)
    else $error("bad end not sending r_err");
  // ****************************************
  // main scenario covers
  // ****************************************
  c_good_crc: cover property (o_state == 4'h7);
  c_hold_ack: cover property (o_state == 4'h5);
  c_no_comm: cover property (o_state == 4'ha);
endmodule
`default_nettype wire

// File: slrx_far_tx.sv
// slrx_far_tx.sv: behavioural far-end transmitter feeding received dwords
`default_nettype none
module slrx_far_tx (
  output logic o_valid,
  output logic o_is_prim,
  output logic [3:0] o_prim,
  output logic [31:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // line drive
  // ****************************************
  // idle line until the first dword
  initial begin
    o_valid = 1'b0;
    o_is_prim = 1'b0;
    o_prim = 4'h0;
    o_data = 32'h0;
  end
  // present one dword; called at a falling edge
  task automatic put(input logic ip, input logic [3:0] c, input logic [31:0] d);
    o_valid = 1'b1;
    o_is_prim = ip;
    o_prim = c;
    o_data = d;
  endtask
  // release: stale prim and data lines go inverted
  task automatic quiet;
    o_valid = 1'b0;
    o_prim = ~o_prim;
    o_data = ~o_data;
  endtask
endmodule
`default_nettype wire

// File: test_slrx_link.sv
// test_slrx_link.sv: self-checking bench of the link receive state machine
`default_nettype none
`include "slrx_map.vh"
module test_slrx_link;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic phy = 1'b1;
  logic buf_rdy = 1'b1;
  logic space = 1'b1;
  logic host = 1'b0;
  logic pend = 1'b0;
  logic dmat = 1'b0;
  logic st_v = 1'b0;
  logic st_g = 1'b0;
  logic rd_rdy = 1'b1;
  logic ce = 1'b1;
  logic rx_v, rx_p, rd_v, e_nc, e_pr, e_ab, e_il, e_ok, e_er;
  logic [3:0] rx_c, txp, st;
  logic [31:0] rx_d, rd_d;
  logic [31:0] got_q[$];
  int bad_count = 0;
  int cmp_count = 0;
  // 100 MHz clock
  always #5 i_clk = ~i_clk;
  slrx_far_tx slrx_far_tx_i (.o_valid(rx_v), .o_is_prim(rx_p), .o_prim(rx_c), .o_data(rx_d));
  slrx_link slrx_link_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce),
    .i_phy_ready_flag(phy), .i_rx_valid(rx_v), .i_rx_is_prim(rx_p), .i_rx_prim(rx_c),
    .i_rx_data(rx_d), .i_buf_ready(buf_rdy), .i_space_ok(space), .i_host_role(host),
    .i_ctrl_frame_pending(pend), .i_dmat_enable(dmat), .i_dmat_request(dmat),
    .i_tl_status_valid(st_v), .i_tl_status_good(st_g), .i_rd_ready(rd_rdy),
    .o_rd_valid(rd_v), .o_rd_data(rd_d), .o_tx_prim(txp), .o_state(st),
    .o_nocomm_evt(e_nc), .o_proto_evt(e_pr), .o_abort_evt(e_ab), .o_illegal_evt(e_il),
    .o_crc_ok_evt(e_ok), .o_crc_err_evt(e_er));
  // words drained by the transport side
  always @(posedge i_clk) if (rd_v === 1'b1 && rd_rdy) got_q.push_back(rd_d);
  // ****************************************
  // helpers
  // ****************************************
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one dword across one rising edge
  task automatic tx(input logic ip, input logic [3:0] c, input logic [31:0] d);
    @(negedge i_clk);
    slrx_far_tx_i.put(ip, c, d);
    @(negedge i_clk);
    slrx_far_tx_i.quiet();
  endtask
  task automatic pr(input logic [3:0] c, input logic [3:0] s, input logic [3:0] t);
    tx(1'b1, c, 32'h0);
    chk("state", s, st);
    chk("tx_prim", t, txp);
  endtask
  task automatic dw(input logic [31:0] d, input logic [3:0] s);
    tx(1'b0, 4'h0, d);
    chk("state", s, st);
  endtask
  task automatic open;
    pr(`SLRX_P_X_RDY, 4'h1, `SLRX_P_R_RDY);
    pr(`SLRX_P_SOF, 4'h3, `SLRX_P_R_IP);
  endtask
  // msb-first frame crc step
  function automatic logic [31:0] crc_of(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `SLRX_CRC_POLY : 32'h0);
    return c;
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_good;
    logic [31:0] c;
    c = crc_of(crc_of(`SLRX_CRC_INIT, 32'h1234abcd), 32'hfedc0001);
    got_q.delete();
    pr(`SLRX_P_X_RDY, 4'h1, `SLRX_P_R_RDY);
    pr(`SLRX_P_X_RDY, 4'h1, `SLRX_P_R_RDY);
    pr(`SLRX_P_SOF, 4'h3, `SLRX_P_R_IP);
    dw(32'h1234abcd, 4'h3);
    dw(32'hfedc0001, 4'h3);
    dw(c, 4'h3);
    pr(`SLRX_P_EOF, 4'h6, `SLRX_P_R_IP);
    @(negedge i_clk);
    chk("state", 4'h7, st);
    chk("crc_ok", 1'b1, e_ok);
    st_v = 1'b1;
    st_g = 1'b1;
    @(negedge i_clk);
    st_v = 1'b0;
    chk("tx_prim", `SLRX_P_R_OK, txp);
    pr(`SLRX_P_SYNC, 4'h0, `SLRX_P_SYNC);
    repeat (4) @(negedge i_clk);
    chk("words", 2, got_q.size());
    if (got_q.size() == 2) chk("word0", 32'h1234abcd, got_q[0]);
    if (got_q.size() == 2) chk("word1", 32'hfedc0001, got_q[1]);
  endtask
  task automatic t_wait;
    buf_rdy = 1'b0;
    pr(`SLRX_P_X_RDY, 4'h2, `SLRX_P_SYNC);
    pr(`SLRX_P_X_RDY, 4'h2, `SLRX_P_SYNC);
    buf_rdy = 1'b1;
    pr(`SLRX_P_X_RDY, 4'h1, `SLRX_P_R_RDY);
    pr(`SLRX_P_R_IP, 4'h0, `SLRX_P_SYNC);
    chk("proto", 1'b1, e_pr);
    buf_rdy = 1'b0;
    pr(`SLRX_P_X_RDY, 4'h2, `SLRX_P_SYNC);
    dw(32'h0bad0bad, 4'h0);
    chk("proto", 1'b1, e_pr);
    buf_rdy = 1'b1;
  endtask
  task automatic t_hold;
    rd_rdy = 1'b0;
    open();
    for (int n = 0; n < 12 && st !== 4'h4; n++) tx(1'b0, 4'h0, 32'h100 + n);
    chk("tx_prim", `SLRX_P_HOLD, txp);
    dw(32'h200, 4'h4);
    rd_rdy = 1'b1;
    repeat (12) @(negedge i_clk);
    pr(`SLRX_P_HOLD, 4'h5, `SLRX_P_HOLDA);
    dmat = 1'b1;
    pr(`SLRX_P_HOLD, 4'h5, `SLRX_P_DMAT);
    dmat = 1'b0;
    dw(32'h300, 4'h3);
    pr(`SLRX_P_HOLD, 4'h5, `SLRX_P_HOLDA);
    pr(`SLRX_P_HOLDA, 4'h3, `SLRX_P_R_IP);
    pr(`SLRX_P_HOLDA, 4'h3, `SLRX_P_R_IP);
    pr(`SLRX_P_HOLD, 4'h5, `SLRX_P_HOLDA);
    pr(`SLRX_P_SYNC, 4'h0, `SLRX_P_SYNC);
    chk("illegal", 1'b1, e_il);
  endtask
  task automatic t_abort;
    open();
    pr(`SLRX_P_SYNC, 4'h0, `SLRX_P_SYNC);
    chk("abort", 1'b1, e_ab);
    open();
    pr(`SLRX_P_WTRM, 4'h9, `SLRX_P_R_ERR);
    pr(`SLRX_P_X_RDY, 4'h9, `SLRX_P_R_ERR);
    pr(`SLRX_P_SYNC, 4'h0, `SLRX_P_SYNC);
    open();
    host = 1'b1;
    pend = 1'b1;
    @(negedge i_clk);
    chk("state", 4'h0, st);
    chk("tx_prim", `SLRX_P_SYNC, txp);
    host = 1'b0;
    pend = 1'b0;
    open();
    space = 1'b0;
    @(negedge i_clk);
    chk("state", 4'h4, st);
    pr(`SLRX_P_SYNC, 4'h0, `SLRX_P_SYNC);
    chk("illegal", 1'b1, e_il);
    open();
    @(negedge i_clk);
    pr(`SLRX_P_EOF, 4'h6, `SLRX_P_R_IP);
    space = 1'b1;
    @(negedge i_clk);
    chk("state", 4'h9, st);
    chk("crc_err", 1'b1, e_er);
    pr(`SLRX_P_SYNC, 4'h0, `SLRX_P_SYNC);
  endtask
  task automatic t_phy;
    open();
    ce = 1'b0;
    phy = 1'b0;
    @(negedge i_clk);
    chk("frozen", 4'h3, st);
    ce = 1'b1;
    @(negedge i_clk);
    chk("state", 4'ha, st);
    chk("nocomm", 1'b1, e_nc);
    @(negedge i_clk);
    chk("nocomm", 1'b0, e_nc);
    phy = 1'b1;
    @(negedge i_clk);
    chk("state", 4'h0, st);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (4) @(negedge i_clk);
    chk("reset state", 4'h0, st);
    chk("reset tx", `SLRX_P_SYNC, txp);
    i_rst_b = 1'b1;
    t_good();
    t_wait();
    t_hold();
    t_abort();
    t_phy();
    tally_and_finish();
  end
  // whole run is about 130 cycles
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
endmodule
bind slrx_link slrx_link_chk slrx_link_chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
  .i_phy_ready_flag(i_phy_ready_flag), .i_rx_valid(i_rx_valid), .i_rx_is_prim(i_rx_is_prim),
  .i_rx_prim(i_rx_prim), .i_buf_ready(i_buf_ready), .i_space_ok(i_space_ok),
  .i_host_role(i_host_role), .i_ctrl_frame_pending(i_ctrl_frame_pending),
  .i_dmat_enable(i_dmat_enable), .o_tx_prim(o_tx_prim), .o_state(o_state),
  .o_nocomm_evt(o_nocomm_evt), .o_proto_evt(o_proto_evt), .o_abort_evt(o_abort_evt),
  .o_illegal_evt(o_illegal_evt));
`default_nettype wire
